// *** rtl/grab_cfg.svh ***
/*
  grab_cfg.svh: offsets, field positions, reset values and timing counts
  of the frame-grabber freeze control core.
  assumes: included by the package, the checker and the bench; definitions only.
*/
`ifndef GRAB_CFG_SVH
`define GRAB_CFG_SVH

// register offsets (byte addresses, one 32-bit word each)
`define OFS_CTRL 8'h00
`define OFS_FREEZE 8'h04
`define OFS_STATUS 8'h08
`define OFS_ADJUST 8'h0C
`define OFS_HOST_ADDR 8'h10
`define OFS_HOST_DATA 8'h14
`define OFS_LUT_DATA 8'h18
`define OFS_LUT_INDEX 8'h1C

// ctrl register fields
`define CTRL_CAM_LSB 0
`define CTRL_FIELD_ONLY 2
`define CTRL_FIELD_SEL 3
`define CTRL_LUT_SRC 4
`define CTRL_BCAST 5
`define CTRL_BANK_LSB 8
`define CTRL_MEM_FREEZE 11
`define CTRL_PAL_WR 12
`define CTRL_RESET 32'h0000_0000

// freeze register fields
`define FRZ_REQ 0
`define FRZ_COND_LSB 1
`define FRZ_TRIG_EN 3

// status register fields
`define ST_DONE 0
`define ST_PENDING 1
`define ST_FIELD 2
`define ST_MEM_FROZEN 3

// host access field: address bits 17..0, 19..18 store select, 20 word
`define HA_STORE_LSB 18
`define HA_WORD 20

// adjust register: gain 5..0, offset 13..8
`define ADJ_GAIN_LSB 0
`define ADJ_OFS_LSB 8
`define ADJ_RESET 14'h2020

// geometry and rates
`define LINE_PIXELS 640
`define FRAME_LINES 480
`define FIELD_LINES 240
`define CLK_HZ 25000000
`define PIX_INT_HZ 20000000
`define PIX_IN_HZ 12500000
`define PIX_INT_NS 50

`endif

// *** rtl/grab_pkg.sv ***
/*
  grab_pkg: types shared by the freeze control core.
  assumes: grab_cfg.svh is on the include path.
*/
`default_nettype none
package grab_pkg;
  `include "grab_cfg.svh"

  typedef enum logic [1:0] {
    COND_ANY_VS = 2'h0,
    COND_F1_F2 = 2'h1,
    COND_F2_F1 = 2'h2
  } freeze_cond_t;

  typedef enum logic [2:0] {
    FRZ_IDLE = 3'b001,
    FRZ_WAIT = 3'b010,
    FRZ_HELD = 3'b100
  } freeze_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic vs;
    logic field2;
    logic [7:0] pix;
    logic valid;
  } video_in_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_t;
endpackage
`default_nettype wire

// *** rtl/frame_grabber_freeze_control.sv ***
/*
  frame_grabber_freeze_control: digital core of a monochrome frame grabber.
  camera select, gain/offset codes, freeze on vertical sync, field memory
  with progressive read-out, field-only output, eight remap banks, display
  store with palette, and host access to the dual-port stores.
  assumes: one 25 MHz clock; camera signals arrive from another domain;
  image-bus logic runs on the same clock; image stores are reduced-size models
  addressed by the low address bits.
*/
`default_nettype none

// Summary of operation
// R1: freeze only when a request is pending and its condition is met.
// R2: conditions: any vsync, vsync after field 1, vsync after field 2.
// R3: frozen frame can be sent as one chosen field only.
// R4: interlaced input stored in field memory, read progressive at 20 MHz.
// R5: frame captured is 640 by 480 pixels.
// R6: input samples are 8 bits at 12.5 MHz.
// R7: one camera channel chosen by software is the active input.
// R8: gain and offset codes of 64 steps each set by software.
// R9: display store written from bus; broadcast mode re-interlaces output.
// R10: display pixels pass a 256-entry palette to three 8-bit outputs.
// R11: host accesses three dual-port stores while the bus uses them.
// R12: fourth store hidden from host, written and read at once.
// R13: host freeze of a store takes effect at next internal vsync.
// R14: first two stores byte only; third store byte and word.
// R15: first two stores pair as 16 bits, even to first, odd second.
// R16: eight remap banks of 256x8; bank change acts at once.
// R17: remap input from bus or video input; output drives the bus.
// R18: freeze completion can raise a host interrupt request.
// R19: bus processing runs at one pixel per 50 ns.
// R20: request stays pending until met, then clears and records done.
module frame_grabber_freeze_control
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire grab_pkg::reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // camera side
  input wire grab_pkg::video_in_t cam_i [4],
  input wire logic ext_trig_i,
  output logic [5:0] gain_code_o,
  output logic [5:0] offset_code_o,
  // internal image bus
  input wire logic [15:0] bus_in_i,
  input wire logic bus_in_valid_i,
  output logic [15:0] bus_out_o,
  output logic bus_out_valid_o,
  output logic bus_vs_o,
  output logic pix_en_o,
  // display side
  output grab_pkg::rgb_t disp_rgb_o,
  output logic disp_pix_en_o,
  // host interrupt
  output logic freeze_irq_o
);
  import grab_pkg::*;

  localparam int STORE_AW = 12;
  localparam int DIV_IN = `CLK_HZ / `PIX_IN_HZ;

  // register file
  logic [31:0] ctrl_reg;
  logic [31:0] freeze_reg;
  logic [13:0] adjust_reg;
  logic [20:0] host_addr_reg;
  logic [7:0] lut_index_reg;
  logic [31:0] rdata_next;
  logic done_reg;
  logic mem_frozen_reg;
  logic field_reg;
  logic irq_en_reg;
  freeze_state_t frz_state_reg;

  function automatic logic hit(input logic [7:0] ofs);
    hit = reg_req_i.addr == ofs;
  endfunction

  // R8: gain and offset, 64 steps each
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= `CTRL_RESET;
      adjust_reg <= `ADJ_RESET;
      host_addr_reg <= 21'h000000;
      lut_index_reg <= 8'h00;
      irq_en_reg <= 1'b0;
    end
    else if (reg_req_i.wr)
    begin
      if (hit(`OFS_CTRL))
        ctrl_reg <= reg_req_i.wdata;
      if (hit(`OFS_ADJUST))
        adjust_reg <= reg_req_i.wdata[13:0];
      if (hit(`OFS_HOST_ADDR))
        host_addr_reg <= reg_req_i.wdata[20:0];
      if (hit(`OFS_LUT_INDEX))
        lut_index_reg <= reg_req_i.wdata[7:0];
      if (hit(`OFS_STATUS))
        irq_en_reg <= reg_req_i.wdata[31];
    end
  end

  // R7: camera select with three-stage synchroniser
  logic [2:0] vs_sync_reg;
  logic [2:0] fld_sync_reg;
  logic [2:0] trig_sync_reg;
  logic [7:0] pix_s1_reg;
  logic [7:0] pix_s2_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vs_sync_reg <= 3'h0;
      fld_sync_reg <= 3'h0;
      trig_sync_reg <= 3'h0;
      pix_s1_reg <= 8'h00;
      pix_s2_reg <= 8'h00;
    end
    else
    begin
      vs_sync_reg <= {vs_sync_reg[1:0], cam_i[ctrl_reg[1:0]].vs};
      fld_sync_reg <= {fld_sync_reg[1:0], cam_i[ctrl_reg[1:0]].field2};
      trig_sync_reg <= {trig_sync_reg[1:0], ext_trig_i};
      pix_s1_reg <= cam_i[ctrl_reg[1:0]].pix;
      pix_s2_reg <= pix_s1_reg;
    end
  end

  logic vs_lvl_reg;
  logic trig_lvl_reg;
  logic fld_lvl_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vs_lvl_reg <= 1'b0;
      trig_lvl_reg <= 1'b0;
      fld_lvl_reg <= 1'b0;
    end
    else
    begin
      if (vs_sync_reg[1] == vs_sync_reg[2])
        vs_lvl_reg <= vs_sync_reg[2];
      if (trig_sync_reg[1] == trig_sync_reg[2])
        trig_lvl_reg <= trig_sync_reg[2];
      if (fld_sync_reg[1] == fld_sync_reg[2])
        fld_lvl_reg <= fld_sync_reg[2];
    end
  end
  logic vs_d_reg;
  logic trig_d_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vs_d_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end
    else
    begin
      vs_d_reg <= vs_lvl_reg;
      trig_d_reg <= trig_lvl_reg;
    end
  end
  wire vs_rise = vs_lvl_reg & ~vs_d_reg;
  wire trig_rise = trig_lvl_reg & ~trig_d_reg;

  // field parity: field 2 flag seen in the field that just ended
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      field_reg <= 1'b0;
    else if (vs_rise)
      field_reg <= fld_lvl_reg;
  end

  // R2: condition decode
  function automatic logic cond_met(input logic [1:0] c, input logic f2);
    case (c)
      COND_ANY_VS: cond_met = 1'b1;
      COND_F1_F2: cond_met = ~f2;
      COND_F2_F1: cond_met = f2;
      default: cond_met = 1'b1;
    endcase
  endfunction

  wire host_req = reg_req_i.wr & hit(`OFS_FREEZE) &
    reg_req_i.wdata[`FRZ_REQ];
  wire freeze_hit = vs_rise &
    cond_met(freeze_reg[`FRZ_COND_LSB +: 2], fld_lvl_reg);
  wire status_rd = reg_req_i.rd & hit(`OFS_STATUS);

  // R1: freeze state machine; R20: pending until met
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frz_state_reg <= FRZ_IDLE;
      freeze_reg <= 32'h0000_0000;
    end
    else
    begin
      if (reg_req_i.wr && hit(`OFS_FREEZE))
        freeze_reg[3:1] <= reg_req_i.wdata[3:1];
      case (frz_state_reg)
        FRZ_IDLE:
          if (host_req || (trig_rise && freeze_reg[`FRZ_TRIG_EN]))
            frz_state_reg <= FRZ_WAIT;
        FRZ_WAIT:
          // R1: condition met while pending
          if (freeze_hit)
            frz_state_reg <= FRZ_HELD;
        FRZ_HELD:
          if (reg_req_i.wr && hit(`OFS_FREEZE) &&
              !reg_req_i.wdata[`FRZ_REQ])
            frz_state_reg <= FRZ_IDLE;
        default:
          frz_state_reg <= FRZ_IDLE;
      endcase
    end
  end

  // R20: done flag, set wins over read clear
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      done_reg <= 1'b0;
    else if (frz_state_reg == FRZ_WAIT && freeze_hit)
      done_reg <= 1'b1;
    else if (status_rd)
      done_reg <= 1'b0;
  end

  // R18: interrupt request on completion
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      freeze_irq_o <= 1'b0;
    else
      freeze_irq_o <= irq_en_reg & done_reg;
  end

  // R6: 12.5 MHz sample enable; R19: 20 MHz pixel enable (4 of 5)
  logic [3:0] in_div_reg;
  logic [2:0] pix_div_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_div_reg <= 4'h0;
      pix_div_reg <= 3'h0;
    end
    else
    begin
      in_div_reg <= (in_div_reg == 4'(DIV_IN - 1)) ? 4'h0 : in_div_reg + 4'h1;
      pix_div_reg <= (pix_div_reg == 3'h4) ? 3'h0 : pix_div_reg + 3'h1;
    end
  end
  wire in_en = in_div_reg == 4'h0;
  wire pix_en = pix_div_reg != 3'h4;

  // R4, R5: field memory; input writes interlaced lines at 2*line+field
  logic [7:0] field_mem [2**STORE_AW];
  logic [9:0] in_x_reg;
  logic [8:0] in_y_reg;
  wire frozen = frz_state_reg == FRZ_HELD;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      in_x_reg <= 10'h000;
      in_y_reg <= 9'h000;
    end
    else if (vs_rise)
    begin
      in_x_reg <= 10'h000;
      in_y_reg <= 9'h000;
    end
    else if (in_en && !frozen)
    begin
      if (in_x_reg == 10'(`LINE_PIXELS - 1))
      begin
        in_x_reg <= 10'h000;
        if (in_y_reg != 9'(`FIELD_LINES - 1))
          in_y_reg <= in_y_reg + 9'h001;
      end
      else
        in_x_reg <= in_x_reg + 10'h001;
    end
  end
  wire [8:0] in_line = {in_y_reg[7:0], fld_lvl_reg};
  always_ff @(posedge clk_i)
  begin
    if (in_en && !frozen)
      field_mem[{in_line[1:0], in_x_reg[9:0]}] <= pix_s2_reg;
  end

  // R4, R3: progressive read-out; field-only skips lines of the other field
  logic [9:0] out_x_reg;
  logic [8:0] out_y_reg;
  logic int_vs_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      out_x_reg <= 10'h000;
      out_y_reg <= 9'h000;
      int_vs_reg <= 1'b0;
    end
    else
    begin
      int_vs_reg <= 1'b0;
      if (pix_en)
      begin
        if (out_x_reg == 10'(`LINE_PIXELS - 1))
        begin
          out_x_reg <= 10'h000;
          if (out_y_reg == 9'(`FRAME_LINES - 1))
          begin
            out_y_reg <= 9'h000;
            int_vs_reg <= 1'b1;
          end
          else
            out_y_reg <= out_y_reg + 9'h001;
        end
        else
          out_x_reg <= out_x_reg + 10'h001;
      end
    end
  end
  wire field_skip = ctrl_reg[`CTRL_FIELD_ONLY] & frozen &
    (out_y_reg[0] != ctrl_reg[`CTRL_FIELD_SEL]);

  // R16: eight banks of 256x8, bank bits act at once; R17 source select
  // video source is the field memory read-out, else the bus input
  logic [7:0] lut_mem [2048];
  logic [7:0] lut_in;
  always_comb
  begin
    lut_in = ctrl_reg[`CTRL_LUT_SRC] ?
      field_mem[{out_y_reg[1:0], out_x_reg}] : bus_in_i[7:0];
  end
  always_ff @(posedge clk_i)
  begin
    if (reg_req_i.wr && hit(`OFS_LUT_DATA))
      lut_mem[{ctrl_reg[`CTRL_BANK_LSB +: 3], lut_index_reg}] <=
        reg_req_i.wdata[7:0];
  end

  // R12: delay store written and read in the same cycle
  logic [7:0] delay_field_store [2**STORE_AW];
  logic [STORE_AW-1:0] dly_ptr_reg;
  logic [7:0] dly_rd_reg;
  // bus partner answers the visible pixel enable
  wire bus_take = bus_in_valid_i & pix_en_o;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      dly_ptr_reg <= '0;
    else if (bus_take)
      dly_ptr_reg <= dly_ptr_reg + 12'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (bus_take)
    begin
      delay_field_store[dly_ptr_reg] <= bus_in_i[15:8];
      dly_rd_reg <= delay_field_store[dly_ptr_reg];
    end
  end

  // R17, R19: bus output per pixel enable
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_out_o <= 16'h0000;
      bus_out_valid_o <= 1'b0;
      bus_vs_o <= 1'b0;
      pix_en_o <= 1'b0;
    end
    else
    begin
      pix_en_o <= pix_en;
      bus_vs_o <= int_vs_reg;
      bus_out_valid_o <= pix_en & ~field_skip;
      if (pix_en)
        bus_out_o <= {dly_rd_reg,
          lut_mem[{ctrl_reg[`CTRL_BANK_LSB +: 3], lut_in}]};
    end
  end

  // R13: host freeze of stores at next internal vsync
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mem_frozen_reg <= 1'b0;
    else if (int_vs_reg)
      mem_frozen_reg <= ctrl_reg[`CTRL_MEM_FREEZE];
  end

  // R11: three dual-port stores, bus writes unless frozen
  logic [7:0] dual_port_store_a [2**STORE_AW];
  logic [7:0] dual_port_store_b [2**STORE_AW];
  logic [15:0] dual_port_store_word [2**STORE_AW];
  wire [STORE_AW-1:0] bus_wa = {out_y_reg[1:0], out_x_reg};
  wire [1:0] h_store = host_addr_reg[`HA_STORE_LSB +: 2];
  wire h_word = host_addr_reg[`HA_WORD];
  wire [STORE_AW-1:0] h_ba = host_addr_reg[STORE_AW-1:0];
  wire [STORE_AW-1:0] h_pa = host_addr_reg[STORE_AW:1];
  wire h_wr = reg_req_i.wr & hit(`OFS_HOST_DATA);
  logic [15:0] host_rd_reg;

  always_ff @(posedge clk_i)
  begin
    if (bus_take && !mem_frozen_reg)
    begin
      dual_port_store_a[bus_wa] <= bus_in_i[7:0];
      dual_port_store_b[bus_wa] <= bus_in_i[15:8];
      dual_port_store_word[bus_wa] <= bus_in_i;
    end
    // R15: paired stores, even to a, odd to b
    if (h_wr && h_store == 2'h0 && !h_word)
    begin
      if (!h_ba[0])
        dual_port_store_a[h_pa] <= reg_req_i.wdata[7:0];
      else
        dual_port_store_b[h_pa] <= reg_req_i.wdata[7:0];
    end
    // R14: word store takes byte or word
    if (h_wr && h_store == 2'h2)
    begin
      if (h_word)
        dual_port_store_word[h_pa] <= reg_req_i.wdata[15:0];
      else if (!h_ba[0])
        dual_port_store_word[h_pa][7:0] <= reg_req_i.wdata[7:0];
      else
        dual_port_store_word[h_pa][15:8] <= reg_req_i.wdata[7:0];
    end
  end

  // R14: pair read gives 16 bits; byte reads give the addressed byte
  always_ff @(posedge clk_i)
  begin
    if (h_store == 2'h2)
      host_rd_reg <= h_word ? dual_port_store_word[h_pa] :
        {8'h00, h_ba[0] ? dual_port_store_word[h_pa][15:8] :
        dual_port_store_word[h_pa][7:0]};
    else if (h_word)
      host_rd_reg <= {dual_port_store_b[h_pa], dual_port_store_a[h_pa]};
    else
      host_rd_reg <= {8'h00, h_ba[0] ? dual_port_store_b[h_pa] :
        dual_port_store_a[h_pa]};
  end

  // R9: display store; broadcast mode reads one field per pass
  logic [7:0] disp_mem [2**STORE_AW];
  logic [7:0] palette [256];
  logic [9:0] dx_reg;
  logic [8:0] dy_reg;
  logic disp_field_reg;
  logic [7:0] disp_pix_reg;
  always_ff @(posedge clk_i)
  begin
    if (bus_take)
      disp_mem[bus_wa] <= bus_in_i[7:0];
    disp_pix_reg <= disp_mem[{dy_reg[1:0], dx_reg}];
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dx_reg <= 10'h000;
      dy_reg <= 9'h000;
      disp_field_reg <= 1'b0;
      disp_pix_en_o <= 1'b0;
    end
    else
    begin
      // broadcast mode paces pixels at the slower input rate
      disp_pix_en_o <= ctrl_reg[`CTRL_BCAST] ? in_en : 1'b1;
      if (ctrl_reg[`CTRL_BCAST] ? in_en : 1'b1)
      begin
        if (dx_reg == 10'(`LINE_PIXELS - 1))
        begin
          dx_reg <= 10'h000;
          if (dy_reg >= 9'(`FRAME_LINES - 2))
          begin
            disp_field_reg <= ~disp_field_reg;
            dy_reg <= ctrl_reg[`CTRL_BCAST] ? {8'h00, ~disp_field_reg} :
              9'h000;
          end
          else
            dy_reg <= dy_reg + (ctrl_reg[`CTRL_BCAST] ? 9'h002 : 9'h001);
        end
        else
          dx_reg <= dx_reg + 10'h001;
      end
    end
  end

  // R10: palette, written through lut data while palette select is set
  always_ff @(posedge clk_i)
  begin
    if (reg_req_i.wr && hit(`OFS_LUT_DATA) && ctrl_reg[`CTRL_PAL_WR])
      palette[lut_index_reg] <= reg_req_i.wdata[7:0];
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      disp_rgb_o <= '0;
    else
      disp_rgb_o <= '{palette[disp_pix_reg], palette[disp_pix_reg],
        palette[disp_pix_reg]};
  end

  // R8: code outputs
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      gain_code_o <= 6'h00;
      offset_code_o <= 6'h00;
    end
    else
    begin
      gain_code_o <= adjust_reg[`ADJ_GAIN_LSB +: 6];
      offset_code_o <= adjust_reg[`ADJ_OFS_LSB +: 6];
    end
  end

  // register read, data valid in the following cycle
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    case (reg_req_i.addr)
      `OFS_CTRL: rdata_next = ctrl_reg;
      `OFS_FREEZE: rdata_next = {freeze_reg[31:1], frz_state_reg != FRZ_IDLE};
      `OFS_STATUS: rdata_next = {irq_en_reg, 27'h0, mem_frozen_reg,
        field_reg, frz_state_reg == FRZ_WAIT, done_reg};
      `OFS_ADJUST: rdata_next = {18'h0, adjust_reg};
      `OFS_HOST_ADDR: rdata_next = {11'h0, host_addr_reg};
      `OFS_HOST_DATA: rdata_next = {16'h0, host_rd_reg};
      `OFS_LUT_INDEX: rdata_next = {24'h0, lut_index_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_req_i.rd)
      reg_rdata_o <= rdata_next;
    else
      reg_rdata_o <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// *** sim/grab_checker.sv ***
/*
  grab_checker: port assertions for the freeze control core.
  assumes: bound to frame_grabber_freeze_control; one clock domain.
*/
`default_nettype none
`include "grab_cfg.svh"
module grab_checker
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched ports
  input wire grab_pkg::reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [5:0] gain_code_o,
  input wire logic [5:0] offset_code_o,
  input wire logic bus_out_valid_o,
  input wire logic bus_vs_o,
  input wire logic pix_en_o,
  input wire grab_pkg::rgb_t disp_rgb_o,
  input wire logic disp_pix_en_o,
  input wire logic freeze_irq_o
);
  import grab_pkg::*;
  logic adj_wr;
  logic st_rd;
  assign adj_wr = reg_req_i.wr && reg_req_i.addr == `OFS_ADJUST;
  assign st_rd = reg_req_i.rd && reg_req_i.addr == `OFS_STATUS;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_pix_rate;
    $fell(pix_en_o) |=> pix_en_o [*4] ##1 !pix_en_o;
  endproperty
  a_pix_rate: assert property (p_pix_rate)
    else $error("pixel enable not four of five");
  property p_valid_pix;
    bus_out_valid_o |-> pix_en_o;
  endproperty
  a_valid_pix: assert property (p_valid_pix)
    else $error("bus valid outside pixel enable");
  property p_vs_pulse;
    bus_vs_o |=> !bus_vs_o;
  endproperty
  a_vs_pulse: assert property (p_vs_pulse)
    else $error("bus vsync longer than one cycle");
  property p_disp_rate;
    !disp_pix_en_o |=> disp_pix_en_o;
  endproperty
  a_disp_rate: assert property (p_disp_rate)
    else $error("display enable low twice");
  property p_rgb_grey;
    disp_rgb_o.red == disp_rgb_o.green && disp_rgb_o.green == disp_rgb_o.blue;
  endproperty
  a_rgb_grey: assert property (p_rgb_grey)
    else $error("colour components differ");
  property p_gain;
    logic [5:0] g;
    (adj_wr, g = reg_req_i.wdata[5:0]) ##1 !adj_wr |=> gain_code_o == g;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code not taken");
  property p_offset;
    logic [5:0] o;
    (adj_wr, o = reg_req_i.wdata[13:8]) ##1 !adj_wr |=> offset_code_o == o;
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset code not taken");
  property p_irq_clear;
    st_rd && freeze_irq_o |=> reg_rdata_o[0] ##[1:2] !freeze_irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("irq not cleared by status read");
endmodule

bind frame_grabber_freeze_control grab_checker grab_checker_i (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o),
  .gain_code_o(gain_code_o),
  .offset_code_o(offset_code_o),
  .bus_out_valid_o(bus_out_valid_o),
  .bus_vs_o(bus_vs_o),
  .pix_en_o(pix_en_o),
  .disp_rgb_o(disp_rgb_o),
  .disp_pix_en_o(disp_pix_en_o),
  .freeze_irq_o(freeze_irq_o)
);
`default_nettype wire

// *** sim/bus_source_model.sv ***
/*
  bus_source_model: image-bus module feeding the core's bus input.
  assumes: paced by the core's pixel enable on the same clock.
*/
`default_nettype none
module bus_source_model
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // image bus
  input wire logic pix_en_i,
  output logic [15:0] bus_data_o,
  output logic bus_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_reg <= 16'h0000;
    else if (pix_en_i)
      cnt_reg <= cnt_reg + 16'h0001;
  end
  // idle cycles carry the inverse so stale data never looks valid
  assign bus_valid_o = pix_en_i;
  assign bus_data_o = pix_en_i ? cnt_reg : ~cnt_reg;
endmodule
`default_nettype wire

// *** sim/tb_frame_grabber_freeze_control.sv ***
/*
  tb_frame_grabber_freeze_control: self-checking bench of the core.
  assumes: checker bound to the core; 25 MHz clock.
*/
`default_nettype none
`include "grab_cfg.svh"
module tb_frame_grabber_freeze_control;
  timeunit 1ns;
  timeprecision 1ps;
  import grab_pkg::*;
  typedef struct {
    logic [31:0] w;
    int bad_ch;
    logic bad_f2;
    logic good_f2;
    logic trig;
    logic [31:0] adj;
  } row_t;
  row_t rows [4] = '{
    '{32'h1, 1, 1'b0, 1'b0, 1'b0, 32'h0000},
    '{32'h3, 0, 1'b1, 1'b0, 1'b0, 32'h3F3F},
    '{32'h5, 0, 1'b0, 1'b1, 1'b0, 32'h153F},
    '{32'h8, 0, 1'b0, 1'b0, 1'b1, 32'h2A00}};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  reg_req_t req = '0;
  video_in_t cam [4] = '{default: '0};
  logic ext_trig_i = 1'b0;
  logic [15:0] bus_in;
  logic [15:0] bus_out;
  logic bus_in_valid;
  logic [31:0] rdata;
  logic [5:0] gain;
  logic [5:0] offs;
  logic pix_en;
  logic disp_en;
  logic irq;
  logic [31:0] d;
  int error_cnt = 0;
  int checks_done = 0;

  always #20 clk_i = ~clk_i;

  frame_grabber_freeze_control frame_grabber_freeze_control_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .cam_i(cam), .ext_trig_i(ext_trig_i),
    .gain_code_o(gain), .offset_code_o(offs), .bus_in_i(bus_in),
    .bus_in_valid_i(bus_in_valid), .bus_out_o(bus_out), .bus_out_valid_o(),
    .bus_vs_o(), .pix_en_o(pix_en), .disp_rgb_o(),
    .disp_pix_en_o(disp_en), .freeze_irq_o(irq));
  bus_source_model bus_source_model_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pix_en_i(pix_en),
    .bus_data_o(bus_in), .bus_valid_o(bus_in_valid));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task vs(input int ch, input logic f2);
    @(posedge clk_i);
    cam[ch].field2 <= f2;
    cam[ch].vs <= 1'b1;
    cyc(8);
    cam[ch].vs <= 1'b0;
    cyc(20);
  endtask
  task rate(input logic [31:0] ctrl, input int pe, input int de);
    int np;
    int nd;
    wr(`OFS_CTRL, ctrl);
    cyc(10);
    np = 0;
    nd = 0;
    repeat (100)
    begin
      cyc(1);
      np += int'(pix_en);
      nd += int'(disp_en);
    end
    chk(32'(np), 32'(pe), "pixel rate");
    chk(32'(nd), 32'(de), "display rate");
  endtask
  task fill(input logic [31:0] c, input logic [7:0] v);
    wr(`OFS_CTRL, c);
    for (int k = 0; k < 256; k++)
    begin
      wr(`OFS_LUT_INDEX, 32'(k));
      wr(`OFS_LUT_DATA, {24'h0, v});
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    cyc(20000);
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    test_done();
  end

  initial
  begin
    cyc(10);
    sys_rst_i <= 1'b0;
    cyc(2);
    chk(32'({offs, gain}), 32'h820, "adjust reset codes");
    rd(`OFS_ADJUST);
    chk(d, 32'h2020, "adjust reset read");
    rd(`OFS_CTRL);
    chk(d, 32'h0, "ctrl reset read");
    $display("test reset done");
    wr(`OFS_STATUS, 32'h8000_0000);
    foreach (rows[i])
    begin
      wr(`OFS_ADJUST, rows[i].adj);
      cyc(3);
      chk(32'({offs, gain}), 32'({rows[i].adj[13:8], rows[i].adj[5:0]}),
          "adjust codes");
      wr(`OFS_FREEZE, rows[i].w);
      vs(rows[i].bad_ch, rows[i].bad_f2);
      rd(`OFS_STATUS);
      chk(d & 32'h1, 32'h0, "freeze too early");
      if (rows[i].trig)
      begin
        ext_trig_i <= 1'b1;
        cyc(4);
        ext_trig_i <= 1'b0;
        cyc(4);
      end
      vs(0, rows[i].good_f2);
      chk(32'(irq), 32'h1, "freeze irq");
      rd(`OFS_STATUS);
      chk(d & 32'h3, 32'h1, "done set, request cleared");
      cyc(3);
      chk(32'(irq), 32'h0, "irq after status read");
      wr(`OFS_FREEZE, 32'h0);
      cyc(30);
      $display("test freeze row %0d done", i);
    end
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20);
    chk(d, 32'h0, "unmapped read");
    rd(`OFS_ADJUST);
    chk(d, 32'h2A00, "adjust kept");
    $display("test unmapped done");
    rate(32'h0, 80, 100);
    rate(32'h20, 80, 50);
    $display("test rates done");
    fill(32'h100, 8'hA5);
    fill(32'h200, 8'h3C);
    cyc(6);
    chk(32'(bus_out[7:0]), 32'h3C, "remap of bus input");
    wr(`OFS_CTRL, 32'h100);
    cyc(6);
    chk(32'(bus_out[7:0]), 32'hA5, "remap bank switch");
    $display("test remap done");
    test_done();
  end
endmodule
`default_nettype wire
